/* File: rtl/ieee488_pkg.sv */
// shared constants and types for the status and poll block
package ieee488_pkg;
  localparam int QDEPTH = 256;
  localparam int QAW = 8;
  localparam logic [8:0] QCOUNT_FULL = 9'h100;
  localparam logic [8:0] QCOUNT_ONE = 9'h001;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] ZERO8 = 8'h00;
  // event flag positions
  localparam int EV_PON = 7;
  localparam int EV_CMD_ERR = 5;
  localparam int EV_EXE_ERR = 4;
  localparam int EV_QRY_ERR = 2;
  localparam int EV_OPC = 0;
  localparam logic [7:0] EV_USED = 8'hB5;
  localparam logic [7:0] EV_RESET = 8'h80;
  // summary byte positions
  localparam int SB_RQS = 6;
  localparam int SB_ESB = 5;
  localparam int SB_MAV = 4;
  localparam logic [7:0] SB_USED = 8'h70;
  localparam logic [7:0] SRE_USED = 8'h30;
  localparam logic [7:0] PRE_USED = 8'h70;
  localparam logic [7:0] SB_RESET = 8'h00;
  // query fault codes
  localparam logic [7:0] QF_INTERRUPTED = 8'h01;
  localparam logic [7:0] QF_DEADLOCK = 8'h02;
  localparam logic [7:0] QF_UNTERMINATED = 8'h03;
  // poll enable byte layout
  localparam int PPE_KEY_HI = 6;
  localparam int PPE_KEY_LO = 4;
  localparam logic [2:0] PPE_KEY = 3'h6;
  localparam int PPE_SENSE = 3;
  localparam int PPE_LINE_HI = 2;
  localparam logic [7:0] ONE8 = 8'h01;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ESE_SET = 4'h1,
    OP_SRE_SET = 4'h2,
    OP_PRE_SET = 4'h3,
    OP_ESE_Q = 4'h4,
    OP_SRE_Q = 4'h5,
    OP_PRE_Q = 4'h6,
    OP_ESR_Q = 4'h7,
    OP_STB_Q = 4'h8,
    OP_OPC = 4'h9,
    OP_CLS = 4'hA,
    OP_QF_Q = 4'hB,
    OP_EF_Q = 4'hC
  } cmd_op_t;
  typedef struct packed {
    cmd_op_t op;
    logic [7:0] arg;
  } cmd_t;
  typedef struct packed {
    logic end_flag;
    logic [7:0] data;
  } qbyte_t;
  typedef enum logic [1:0] {
    PP_IDLE = 2'b00,
    PP_ARMED = 2'b01,
    PP_ON = 2'b11
  } pp_state_t;
endpackage

/* File: rtl/input_queue.sv */
// raw input byte queue between bus acceptor and parser
`timescale 1ns/1ps
module input_queue (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic flush,
  input ieee488_pkg::qbyte_t in_byte,
  input wire logic in_valid,
  output logic in_ready,
  output ieee488_pkg::qbyte_t out_byte,
  output logic out_valid,
  input wire logic out_pop,
  output logic full,
  output logic empty,
  output logic [8:0] end_count
);
  ieee488_pkg::qbyte_t mem [ieee488_pkg::QDEPTH];
  logic [ieee488_pkg::QAW-1:0] wr_ptr_reg;
  logic [ieee488_pkg::QAW-1:0] rd_ptr_reg;
  logic [8:0] count_reg;
  logic [8:0] ends_reg;
  logic push;
  logic pop;

  assign full = (count_reg == ieee488_pkg::QCOUNT_FULL);
  assign empty = (count_reg == 9'h000);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_byte = mem[rd_ptr_reg];
  assign end_count = ends_reg;
  assign push = in_valid && in_ready;
  assign pop = out_pop && out_valid;

  // no reset on storage; only pointers and counts need a defined value
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_byte;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= 8'h00;
      rd_ptr_reg <= 8'h00;
      count_reg <= 9'h000;
      ends_reg <= 9'h000;
    end
    else if (flush)
    begin
      wr_ptr_reg <= 8'h00;
      rd_ptr_reg <= 8'h00;
      count_reg <= 9'h000;
      ends_reg <= 9'h000;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 8'h01;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 8'h01;
      end
      count_reg <= count_reg + {8'h00, push} - {8'h00, pop};
      ends_reg <= ends_reg + {8'h00, push && in_byte.end_flag}
        - {8'h00, pop && out_byte.end_flag};
    end
  end
endmodule // input_queue

/* File: rtl/ieee488_status_and_poll.sv */
// status reporting, poll and query fault logic of the bus instrument
// Operation
// RL1: talk with nothing to say: code 3
// RL2: pending reply interrupted: code 1, discard
// RL3: pending reply and full queue: code 2
// RL4: ist is OR of poll mask AND status
// RL5: poll byte: key 110, sense, line
// RL6: controller sends configure before enable byte
// RL7: summary bit 5 from masked event flags
// RL8: event flag query returns then clears
// RL9: masks written by set, read by query
// RL10: event flag bit map fixed
// RL11: syntax error flags, resets parser
// RL12: execution failure flags and stores code
// RL13: completion command sets bit 0
// RL14: masked status sets bit 6, service request
// RL15: query gives summary, serial poll gives request
// RL16: message available until terminator sent
// RL17: power on: flags 128, rest zero
// RL18: memory fault warns and loads defaults
// RL19: talker listener, no controller role
// RL20: input queue holds 256 bytes
// RL21: three message terminator forms accepted
// RL22: unused bits read zero, ignore writes
// RL23: fault codes hold until power or clear
`timescale 1ns/1ps
module ieee488_status_and_poll (
  input wire logic clock,
  input wire logic rst_n,
  input ieee488_pkg::qbyte_t bus_byte,
  input wire logic bus_valid,
  output logic bus_ready,
  output ieee488_pkg::qbyte_t parse_byte,
  output logic parse_valid,
  input wire logic parse_pop,
  output logic parser_reset,
  input wire logic dev_clear,
  input wire logic talk_addressed,
  input wire logic resp_ready,
  input wire logic resp_term_sent,
  output logic resp_discard,
  input wire logic cmd_valid,
  input ieee488_pkg::cmd_t cmd,
  output logic ans_valid,
  output logic [7:0] ans_data,
  input wire logic syntax_err,
  input wire logic exec_err,
  input wire logic [7:0] exec_code,
  input wire logic spoll,
  output logic [7:0] spoll_data,
  output logic srq,
  input wire logic pp_config,
  input wire logic pp_enable_cmd,
  input wire logic [7:0] pp_byte,
  input wire logic pp_poll,
  output logic [7:0] pp_dio_out,
  output logic [7:0] pp_dio_oe,
  output logic ist,
  input wire logic nvm_err,
  output logic nvm_warn,
  output logic defaults_load
);
  logic [7:0] event_flags_reg;
  logic [7:0] event_flags_mask_reg;
  logic [7:0] service_req_mask_reg;
  logic [7:0] poll_line_mask_reg;
  logic [7:0] query_fault_code_reg;
  logic [7:0] exec_fault_code_reg;
  logic mav_reg;
  logic rqs_reg;
  logic mss_q_reg;
  logic pp_sense_reg;
  logic [2:0] pp_line_reg;
  ieee488_pkg::pp_state_t pp_state_reg;
  logic [7:0] summary_byte;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic q_full;
  logic q_empty;
  logic [8:0] q_ends;
  logic term_pop;
  logic qf_unterm;
  logic qf_intr;
  logic qf_dead;
  logic qf_any;
  logic esb;
  logic mss;
  logic is_cmd;

  // queue capacity sets the deadlock point [RL20]
  input_queue u_queue (
    .clock(clock),
    .rst_n(rst_n),
    .flush(dev_clear),
    .in_byte(bus_byte),
    .in_valid(bus_valid),
    .in_ready(bus_ready),
    .out_byte(parse_byte),
    .out_valid(parse_valid),
    .out_pop(parse_pop),
    .full(q_full),
    .empty(q_empty),
    .end_count(q_ends)
  );

  // lf alone, lf with end, or end on last byte [RL21]
  assign term_pop = parse_pop && parse_valid
    && ((parse_byte.data == ieee488_pkg::CHAR_LF) || parse_byte.end_flag);
  // single talk address, no controller side ports [RL19]
  assign qf_unterm = talk_addressed && !mav_reg && q_empty; // [RL1]
  assign qf_dead = mav_reg && q_full; // [RL3]
  assign qf_intr = mav_reg && !q_full
    && (term_pop || (q_ends > ieee488_pkg::QCOUNT_ONE)); // [RL2]
  assign qf_any = qf_unterm || qf_dead || qf_intr;
  assign is_cmd = cmd_valid;

  assign esb = |(event_flags_reg & event_flags_mask_reg); // [RL7]
  always_comb
  begin
    summary_byte = ieee488_pkg::SB_RESET;
    summary_byte[ieee488_pkg::SB_ESB] = esb; // [RL7]
    summary_byte[ieee488_pkg::SB_MAV] = mav_reg; // [RL16]
  end
  assign mss = |(summary_byte & service_req_mask_reg
    & ieee488_pkg::SRE_USED); // [RL14]
  // ist formed from the status with bit 6 as master summary [RL4]
  assign ist = |(poll_line_mask_reg
    & (summary_byte | {1'b0, mss, 6'h00}));

  always_comb
  begin
    ev_set = ieee488_pkg::ZERO8;
    ev_set[ieee488_pkg::EV_CMD_ERR] = syntax_err; // [RL11]
    ev_set[ieee488_pkg::EV_EXE_ERR] = exec_err; // [RL12]
    ev_set[ieee488_pkg::EV_QRY_ERR] = qf_any; // [RL1] [RL2] [RL3]
    ev_set[ieee488_pkg::EV_OPC] = is_cmd
      && (cmd.op == ieee488_pkg::OP_OPC); // [RL13]
    ev_clr = ieee488_pkg::ZERO8;
    if (is_cmd && ((cmd.op == ieee488_pkg::OP_ESR_Q)
      || (cmd.op == ieee488_pkg::OP_CLS)))
    begin
      ev_clr = 8'hFF; // [RL8]
    end
  end

  // set wins over the read clear so no event is lost [RL8] [RL10] [RL22]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_flags_reg <= ieee488_pkg::EV_RESET; // [RL17]
    end
    else
    begin
      event_flags_reg <= ((event_flags_reg & ~ev_clr) | ev_set)
        & ieee488_pkg::EV_USED;
    end
  end

  // mask registers [RL9] [RL22]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_flags_mask_reg <= ieee488_pkg::ZERO8; // [RL17]
      service_req_mask_reg <= ieee488_pkg::ZERO8;
      poll_line_mask_reg <= ieee488_pkg::ZERO8;
    end
    else if (is_cmd)
    begin
      case (cmd.op)
        ieee488_pkg::OP_ESE_SET:
          event_flags_mask_reg <= cmd.arg & ieee488_pkg::EV_USED; // [RL9]
        ieee488_pkg::OP_SRE_SET:
          service_req_mask_reg <= cmd.arg & ieee488_pkg::SRE_USED;
        ieee488_pkg::OP_PRE_SET:
          poll_line_mask_reg <= cmd.arg & ieee488_pkg::PRE_USED;
        default:
          event_flags_mask_reg <= event_flags_mask_reg;
      endcase
    end
  end

  // fault codes hold until reset or clear command [RL23]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      query_fault_code_reg <= ieee488_pkg::ZERO8; // [RL17]
      exec_fault_code_reg <= ieee488_pkg::ZERO8;
    end
    else
    begin
      if (qf_dead)
      begin
        query_fault_code_reg <= ieee488_pkg::QF_DEADLOCK; // [RL3]
      end
      else if (qf_intr)
      begin
        query_fault_code_reg <= ieee488_pkg::QF_INTERRUPTED; // [RL2]
      end
      else if (qf_unterm)
      begin
        query_fault_code_reg <= ieee488_pkg::QF_UNTERMINATED; // [RL1]
      end
      else if (is_cmd && (cmd.op == ieee488_pkg::OP_CLS))
      begin
        query_fault_code_reg <= ieee488_pkg::ZERO8; // [RL23]
      end
      if (exec_err)
      begin
        exec_fault_code_reg <= exec_code; // [RL12]
      end
      else if (is_cmd && (cmd.op == ieee488_pkg::OP_CLS))
      begin
        exec_fault_code_reg <= ieee488_pkg::ZERO8;
      end
    end
  end

  // reply bookkeeping; discard beats a late ready [RL16]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mav_reg <= 1'b0;
      resp_discard <= 1'b0;
      parser_reset <= 1'b0;
    end
    else
    begin
      resp_discard <= qf_dead || qf_intr; // [RL2] [RL3]
      parser_reset <= qf_unterm || syntax_err || dev_clear; // [RL1] [RL11]
      if (qf_dead || qf_intr || resp_term_sent || dev_clear)
      begin
        mav_reg <= 1'b0;
      end
      else if (resp_ready)
      begin
        mav_reg <= 1'b1; // [RL16]
      end
    end
  end

  // query answers, one cycle after the command
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ans_valid <= 1'b0;
      ans_data <= ieee488_pkg::ZERO8;
    end
    else
    begin
      ans_valid <= 1'b0;
      if (is_cmd)
      begin
        ans_valid <= 1'b1;
        case (cmd.op)
          ieee488_pkg::OP_ESE_Q: ans_data <= event_flags_mask_reg; // [RL9]
          ieee488_pkg::OP_SRE_Q: ans_data <= service_req_mask_reg;
          ieee488_pkg::OP_PRE_Q: ans_data <= poll_line_mask_reg;
          ieee488_pkg::OP_ESR_Q: ans_data <= event_flags_reg; // [RL8]
          ieee488_pkg::OP_STB_Q:
            ans_data <= summary_byte | {1'b0, mss, 6'h00}; // [RL15]
          ieee488_pkg::OP_QF_Q: ans_data <= query_fault_code_reg;
          ieee488_pkg::OP_EF_Q: ans_data <= exec_fault_code_reg;
          default: ans_valid <= 1'b0;
        endcase
      end
    end
  end

  // request stays until polled or summary falls [RL14] [RL15]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rqs_reg <= 1'b0;
      mss_q_reg <= 1'b0;
      spoll_data <= ieee488_pkg::ZERO8;
    end
    else
    begin
      mss_q_reg <= mss;
      if (mss && !mss_q_reg)
      begin
        rqs_reg <= 1'b1; // [RL14]
      end
      else if (spoll || !mss)
      begin
        rqs_reg <= 1'b0;
      end
      if (spoll)
      begin
        spoll_data <= summary_byte | {1'b0, rqs_reg, 6'h00}; // [RL15]
      end
    end
  end
  assign srq = rqs_reg; // [RL14]

  // configure must precede the enable byte [RL6] [RL5]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pp_state_reg <= ieee488_pkg::PP_IDLE;
      pp_sense_reg <= 1'b0;
      pp_line_reg <= 3'h0;
    end
    else
    begin
      case (pp_state_reg)
        ieee488_pkg::PP_IDLE,
        ieee488_pkg::PP_ON:
          if (pp_config)
          begin
            pp_state_reg <= ieee488_pkg::PP_ARMED; // [RL6]
          end
        ieee488_pkg::PP_ARMED:
          if (pp_enable_cmd)
          begin
            // bit 7 ignored; other keys disable [RL5]
            if (pp_byte[ieee488_pkg::PPE_KEY_HI:ieee488_pkg::PPE_KEY_LO]
              == ieee488_pkg::PPE_KEY)
            begin
              pp_state_reg <= ieee488_pkg::PP_ON;
              pp_sense_reg <= pp_byte[ieee488_pkg::PPE_SENSE];
              pp_line_reg <= pp_byte[ieee488_pkg::PPE_LINE_HI:0];
            end
            else
            begin
              pp_state_reg <= ieee488_pkg::PP_IDLE;
            end
          end
        default:
          pp_state_reg <= ieee488_pkg::PP_IDLE;
      endcase
    end
  end

  // drive only the chosen line, passive otherwise [RL4] [RL5]
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pp_dio_out <= ieee488_pkg::ZERO8;
      pp_dio_oe <= ieee488_pkg::ZERO8;
    end
    else if (pp_poll && (pp_state_reg == ieee488_pkg::PP_ON)
      && (ist == pp_sense_reg))
    begin
      pp_dio_out <= ieee488_pkg::ONE8 << pp_line_reg;
      pp_dio_oe <= ieee488_pkg::ONE8 << pp_line_reg;
    end
    else
    begin
      pp_dio_out <= ieee488_pkg::ZERO8;
      pp_dio_oe <= ieee488_pkg::ZERO8;
    end
  end

  // status itself is volatile; settings reload is left to the owner
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nvm_warn <= 1'b0;
      defaults_load <= 1'b0;
    end
    else
    begin
      defaults_load <= nvm_err; // [RL18]
      if (nvm_err)
      begin
        nvm_warn <= 1'b1; // [RL18]
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_UNTERM: assert property (qf_unterm |=> // [RL1]
    (query_fault_code_reg == ieee488_pkg::QF_UNTERMINATED)
    && event_flags_reg[ieee488_pkg::EV_QRY_ERR] && parser_reset)
    else $error("unterminated fault not reported");
  AST_INTR: assert property (mav_reg && term_pop && !q_full |=> // [RL2]
    (query_fault_code_reg == ieee488_pkg::QF_INTERRUPTED)
    && resp_discard && !mav_reg)
    else $error("interrupted fault not reported");
  AST_DEAD: assert property (mav_reg && q_full |=> // [RL3]
    (query_fault_code_reg == ieee488_pkg::QF_DEADLOCK) && resp_discard)
    else $error("deadlock fault not reported");
  AST_PP_DRIVE: assert property (pp_poll && (ist == pp_sense_reg) // [RL5]
    && (pp_state_reg == ieee488_pkg::PP_ON)
    |=> pp_dio_oe == (ieee488_pkg::ONE8 << $past(pp_line_reg)))
    else $error("poll line not driven");
  AST_PP_QUIET: assert property (!pp_poll |=> pp_dio_oe == 8'h00) // [RL4]
    else $error("poll line driven outside poll");
  AST_ESR_CLR: assert property (is_cmd // [RL8]
    && (cmd.op == ieee488_pkg::OP_ESR_Q) && (ev_set == 8'h00)
    |=> (event_flags_reg == 8'h00) && ans_valid
    && (ans_data == $past(event_flags_reg)))
    else $error("event flags not returned then cleared");
  AST_ESB: assert property (is_cmd && (cmd.op == ieee488_pkg::OP_STB_Q) // [RL7]
    |=> ans_data[ieee488_pkg::SB_ESB] == $past(esb))
    else $error("summary bit 5 wrong");
  AST_SRQ: assert property (mss && !mss_q_reg |=> srq) // [RL14]
    else $error("service request missing");
  AST_SPOLL: assert property (spoll |=> // [RL15]
    spoll_data[ieee488_pkg::SB_RQS] == $past(rqs_reg))
    else $error("serial poll bit 6 wrong");
  AST_UNUSED: assert property (((event_flags_reg & ~ieee488_pkg::EV_USED) // [RL22]
    | (service_req_mask_reg & ~ieee488_pkg::SRE_USED)) == 8'h00)
    else $error("unused bits set");
  AST_OPC: assert property (is_cmd && (cmd.op == ieee488_pkg::OP_OPC) // [RL13]
    |=> event_flags_reg[ieee488_pkg::EV_OPC])
    else $error("completion bit not set");
  AST_MAV: assert property (resp_term_sent |=> !mav_reg) // [RL16]
    else $error("message available not cleared");

  COV_UNTERM: cover property (qf_unterm);
  COV_DEAD: cover property (qf_dead);
  COV_PP: cover property (pp_dio_oe != 8'h00);
  COV_SPOLL: cover property (srq && spoll);
endmodule // ieee488_status_and_poll

/* File: dv/bus_ctl_model.sv */
// bus controller model: bytes, talk address, clear and poll messages
`timescale 1ns/1ps
module bus_ctl_model (
  input wire logic clock,
  input wire logic bus_ready,
  output ieee488_pkg::qbyte_t bus_byte,
  output logic bus_valid,
  output logic talk_addressed,
  output logic dev_clear,
  output logic spoll,
  output logic pp_config,
  output logic pp_enable_cmd,
  output logic [7:0] pp_byte,
  output logic pp_poll
);
  // offered bytes in bus order, kept for the bench to compare
  ieee488_pkg::qbyte_t sent[$];
  initial
  begin
    bus_byte = '0;
    bus_valid = 1'b0;
    pp_byte = 8'h00;
    pp_poll = 1'b0;
    {talk_addressed, dev_clear, spoll, pp_config, pp_enable_cmd} = '0;
  end
  task automatic send(input ieee488_pkg::qbyte_t b);
    @(negedge clock);
    bus_byte = b;
    bus_valid = 1'b1;
    // byte is held until an edge sees the queue willing
    while (bus_ready !== 1'b1)
      @(negedge clock);
    @(negedge clock);
    sent.push_back(b);
    bus_valid = 1'b0;
    // released lines show no stale byte
    bus_byte = ~b;
  endtask
  task automatic pulse(input int k);
    @(negedge clock);
    case (k)
      0: talk_addressed = 1'b1;
      1: dev_clear = 1'b1;
      2: spoll = 1'b1;
      default: pp_config = 1'b1;
    endcase
    @(negedge clock);
    {talk_addressed, dev_clear, spoll, pp_config} = '0;
  endtask
  task automatic configure(input logic [7:0] b);
    pulse(3);
    pp_enable_cmd = 1'b1;
    pp_byte = b;
    @(negedge clock);
    pp_enable_cmd = 1'b0;
    pp_byte = ~b;
  endtask
  task automatic poll(input logic on);
    @(negedge clock);
    pp_poll = on;
  endtask
endmodule // bus_ctl_model

/* File: dv/tb.sv */
// self-checking bench for the status and poll block
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  ieee488_pkg::qbyte_t bus_byte, parse_byte;
  logic bus_valid, bus_ready, parse_valid, parser_reset, dev_clear, spoll;
  logic talk_addressed, resp_discard, ans_valid, srq, ist, pp_poll;
  logic pp_config, pp_enable_cmd, nvm_warn, defaults_load;
  logic [7:0] ans_data, spoll_data, pp_byte, pp_dio_out, pp_dio_oe;
  logic parse_pop, resp_ready, resp_term_sent, cmd_valid, syntax_err;
  logic exec_err, nvm_err;
  logic [7:0] exec_code;
  ieee488_pkg::cmd_t cmd;
  int n_mismatch = 0, n_compared = 0, n_prst = 0, n_disc = 0, n_dflt = 0;
  int seed = 99581;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  ieee488_pkg::cmd_op_t qop[6] = '{ieee488_pkg::OP_ESE_Q,
    ieee488_pkg::OP_SRE_Q, ieee488_pkg::OP_PRE_Q, ieee488_pkg::OP_QF_Q,
    ieee488_pkg::OP_EF_Q, ieee488_pkg::OP_STB_Q};
  ieee488_pkg::cmd_op_t sop[3] = '{ieee488_pkg::OP_ESE_SET,
    ieee488_pkg::OP_SRE_SET, ieee488_pkg::OP_PRE_SET};
  logic [7:0] used[3] = '{ieee488_pkg::EV_USED, ieee488_pkg::SRE_USED,
    ieee488_pkg::PRE_USED};
  logic [7:0] ppb[5] = '{8'h69, 8'hE9, 8'h61, 8'h29, 8'h6E};
  logic [7:0] ppx[5] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h40};

  always #5 clock = ~clock;

  ieee488_status_and_poll u_ieee488_status_and_poll (
    .clock, .rst_n, .bus_byte, .bus_valid, .bus_ready, .parse_byte,
    .parse_valid, .parse_pop, .parser_reset, .dev_clear, .talk_addressed,
    .resp_ready, .resp_term_sent, .resp_discard, .cmd_valid, .cmd,
    .ans_valid, .ans_data, .syntax_err, .exec_err, .exec_code, .spoll,
    .spoll_data, .srq, .pp_config, .pp_enable_cmd, .pp_byte, .pp_poll,
    .pp_dio_out, .pp_dio_oe, .ist, .nvm_err, .nvm_warn, .defaults_load
  );
  bus_ctl_model ctl (
    .clock, .bus_ready, .bus_byte, .bus_valid, .talk_addressed, .dev_clear,
    .spoll, .pp_config, .pp_enable_cmd, .pp_byte, .pp_poll
  );

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_cmd(input ieee488_pkg::cmd_op_t op, input logic [7:0] a,
    input logic [7:0] e, input bit q);
    @(negedge clock);
    cmd.op = op;
    cmd.arg = a;
    cmd_valid = 1'b1;
    if (q)
      exp_q.push_back(e);
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd.arg = ~a;
  endtask
  task automatic pulse(input int k);
    @(negedge clock);
    case (k)
      0: syntax_err = 1'b1;
      1: exec_err = 1'b1;
      2: resp_ready = 1'b1;
      3: resp_term_sent = 1'b1;
      4: parse_pop = 1'b1;
      default: nvm_err = 1'b1;
    endcase
    @(negedge clock);
    {syntax_err, exec_err, resp_ready, resp_term_sent, parse_pop} = '0;
    nvm_err = 1'b0;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // answers are matched oldest first against the driver's notes
  always @(negedge clock)
  begin
    if (parser_reset === 1'b1)
      n_prst++;
    if (resp_discard === 1'b1)
      n_disc++;
    if (defaults_load === 1'b1)
      n_dflt++;
    if (ans_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_mismatch++;
        $display("[FAIL] %0t answer with nothing expected", $time);
      end
      else
        check(ans_data, exp_q.pop_front());
    end
  end

  initial
  begin
    #100000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    {parse_pop, resp_ready, resp_term_sent, cmd_valid} = '0;
    {syntax_err, exec_err, nvm_err} = '0;
    exec_code = 8'($random(seed));
    cmd = '0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h80, 1);
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h00, 1);
    for (int i = 0; i < 6; i++)
      do_cmd(qop[i], 8'h00, 8'h00, 1);
    $display("reset values done");
    for (int i = 0; i < 3; i++)
      for (int j = 0; j < 3; j++)
      begin
        v = (j == 0) ? 8'hFF : ((j == 1) ? 8'($random(seed)) : 8'h00);
        do_cmd(sop[i], v, 8'h00, 0);
        do_cmd(qop[i], 8'h00, v & used[i], 1);
      end
    $display("mask registers done");
    pulse(0);
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h20, 1);
    check(9'(n_prst), 9'h001);
    exec_code = 8'h80 | 8'($random(seed));
    pulse(1);
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h10, 1);
    do_cmd(ieee488_pkg::OP_EF_Q, 8'h00, exec_code, 1);
    do_cmd(ieee488_pkg::OP_OPC, 8'h00, 8'h00, 0);
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h01, 1);
    ctl.pulse(0);
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h04, 1);
    do_cmd(ieee488_pkg::OP_QF_Q, 8'h00, 8'h03, 1);
    check(9'(n_prst), 9'h002);
    do_cmd(ieee488_pkg::OP_EF_Q, 8'h00, exec_code, 1);
    do_cmd(ieee488_pkg::OP_CLS, 8'h00, 8'h00, 0);
    do_cmd(ieee488_pkg::OP_QF_Q, 8'h00, 8'h00, 1);
    $display("event flags done");
    pulse(2);
    do_cmd(ieee488_pkg::OP_STB_Q, 8'h00, 8'h10, 1);
    pulse(3);
    do_cmd(ieee488_pkg::OP_STB_Q, 8'h00, 8'h00, 1);
    pulse(2);
    ctl.send('{1'b0, 8'h0A});
    check(parse_byte, ctl.sent.pop_front());
    pulse(4);
    do_cmd(ieee488_pkg::OP_QF_Q, 8'h00, 8'h01, 1);
    do_cmd(ieee488_pkg::OP_STB_Q, 8'h00, 8'h00, 1);
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h04, 1);
    do_cmd(ieee488_pkg::OP_CLS, 8'h00, 8'h00, 0);
    pulse(2);
    ctl.send('{1'b1, 8'h41});
    ctl.send('{1'b1, 8'h42});
    do_cmd(ieee488_pkg::OP_QF_Q, 8'h00, 8'h01, 1);
    check(9'(n_disc), 9'h002);
    ctl.pulse(1);
    check(parse_valid, 1'b0);
    ctl.sent.delete();
    $display("interrupted done");
    pulse(2);
    repeat (256)
      ctl.send('{1'b0, 8'h20 | (8'($random(seed)) & 8'h3F)});
    check(bus_ready, 1'b0);
    do_cmd(ieee488_pkg::OP_QF_Q, 8'h00, 8'h02, 1);
    do_cmd(ieee488_pkg::OP_STB_Q, 8'h00, 8'h00, 1);
    check(9'(n_disc), 9'h003);
    repeat (3)
    begin
      check(parse_byte, ctl.sent.pop_front());
      pulse(4);
    end
    check(bus_ready, 1'b1);
    ctl.pulse(1);
    $display("deadlock done");
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h04, 1);
    do_cmd(ieee488_pkg::OP_ESE_SET, 8'h20, 8'h00, 0);
    do_cmd(ieee488_pkg::OP_SRE_SET, 8'h20, 8'h00, 0);
    pulse(0);
    do_cmd(ieee488_pkg::OP_STB_Q, 8'h00, 8'h60, 1);
    check(srq, 1'b1);
    ctl.pulse(2);
    check(spoll_data, 8'h60);
    repeat (2) @(negedge clock);
    check(srq, 1'b0);
    do_cmd(ieee488_pkg::OP_STB_Q, 8'h00, 8'h60, 1);
    ctl.pulse(2);
    check(spoll_data, 8'h20);
    do_cmd(ieee488_pkg::OP_PRE_SET, 8'h10, 8'h00, 0);
    check(ist, 1'b0);
    do_cmd(ieee488_pkg::OP_PRE_SET, 8'h40, 8'h00, 0);
    check(ist, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      ctl.configure(ppb[i]);
      ctl.poll(1'b1);
      repeat (2) @(negedge clock);
      check(pp_dio_oe, ppx[i]);
      check(pp_dio_out, ppx[i]);
      ctl.poll(1'b0);
    end
    do_cmd(ieee488_pkg::OP_ESR_Q, 8'h00, 8'h20, 1);
    check(ist, 1'b0);
    $display("polls done");
    pulse(5);
    @(negedge clock);
    check(nvm_warn, 1'b1);
    check(9'(n_dflt), 9'h001);
    check(9'(exp_q.size()), 9'h000);
    $display("power fault done");
    end_sim();
  end
endmodule // tb
